// [pov_port_regs.v]
/*
  Port registers for ports A, B, C and the LCD-shared port J, with the
  LCD and pin-change overrides of port J, behind an AHB-Lite slave.
  Assumes pin inputs are synchronous to CLK and a single bus master.
*/
// Contract
// R1: Port J bit1: change source 25, segment 34
// R2: Port J bit0: change source 24, segment 35
// R3: LCD on: pull-up off, input; output untouched
// R4: Pins 6-4 input buffer off on mask+enables
// R5: Pins 3-0 input buffer off on mask+enables
// R6: Global pull-up disable kills every pull-up
// R7: Pull-up on when direction 0, data 1
// R8: Direction registers, reset zero, A at 0x01
// R9: Input level registers, A at 0x00
// R10: Output registers, reset zero, B 0x05, C 0x08
// R11: Control register 0x35, bits 3,2 read zero
// R12: LCD off: plain GPIO on port J
`timescale 1ns/100ps
`include "pov_defines.vh"

module pov_port_regs #(
  parameter ADDR_W = 12
) (
  input  wire              CLK,
  input  wire              SYS_RST,
  input  wire              HSEL,
  input  wire [ADDR_W-1:0] HADDR,
  input  wire [1:0]        HTRANS,
  input  wire              HWRITE,
  input  wire [2:0]        HSIZE,
  input  wire [31:0]       HWDATA,
  input  wire              HREADY,
  output wire [31:0]       HRDATA,
  output wire              HREADYOUT,
  output wire              HRESP,
  input  wire [7:0]        PA_IN,
  output wire [7:0]        PA_OUT,
  output wire [7:0]        PA_OE_N,
  output wire [7:0]        PA_PULLUP,
  input  wire [7:0]        PB_IN,
  output wire [7:0]        PB_OUT,
  output wire [7:0]        PB_OE_N,
  output wire [7:0]        PB_PULLUP,
  input  wire [7:0]        PC_IN,
  output wire [7:0]        PC_OUT,
  output wire [7:0]        PC_OE_N,
  output wire [7:0]        PC_PULLUP,
  input  wire [7:0]        PJ_IN,
  output wire [7:0]        PJ_OUT,
  output wire [7:0]        PJ_OE_N,
  output wire [7:0]        PJ_PULLUP,
  output wire [7:0]        PJ_INPUT_EN,
  output wire [6:0]        LCD_SEG_CONNECT,
  output wire [6:0]        PIN_CHANGE_SRC,
  output wire              IRQ
);

  // ==========================================================
  // Helpers
  function pov_mapped;
    input [7:0] idx;
    begin
      case (idx)
        `POV_IDX_A_IN, `POV_IDX_A_DIR, `POV_IDX_A_OUT,
        `POV_IDX_B_IN, `POV_IDX_B_DIR, `POV_IDX_B_OUT,
        `POV_IDX_C_IN, `POV_IDX_C_DIR, `POV_IDX_C_OUT,
        `POV_IDX_MCU, `POV_IDX_J_IN, `POV_IDX_J_DIR,
        `POV_IDX_J_OUT, `POV_IDX_LCD_CTRL, `POV_IDX_PC_MASK,
        `POV_IDX_IRQ_STAT, `POV_IDX_IRQ_MASK:
          pov_mapped = 1'b1;
        default:
          pov_mapped = 1'b0;
      endcase
    end
  endfunction

  // Direction 0 with data 1 asks for a pull-up
  function [7:0] pov_pullup;
    input [7:0] dir;
    input [7:0] dat;
    input       pu_off;
    begin
      pov_pullup = ~dir & dat & {8{~pu_off}}; // [R6] [R7]
    end
  endfunction

  // ==========================================================
  // State
  localparam NPORT  = 4;
  localparam J_PORT = 3;

  reg  [7:0]  out_q [0:3];
  reg  [7:0]  dir_q [0:3];
  reg  [31:0] lvl_q;
  reg  [7:0]  mcu_q;
  reg  [7:0]  lcd_q;
  reg  [7:0]  pcmask_q;
  reg  [7:0]  stat_q;
  reg  [7:0]  stat_d;
  reg  [7:0]  imask_q;
  reg         rd_pend_q;
  reg         wr_pend_q;
  reg         map_q;
  reg  [7:0]  addr_q;
  reg  [31:0] hrdata_q;
  reg         hready_q;
  reg         hresp_q;
  reg  [31:0] pin_out_q;
  reg  [31:0] oe_n_q;
  reg  [31:0] pull_q;
  reg  [7:0]  j_in_en_q;
  reg  [6:0]  lcd_pin_q;
  reg  [6:0]  pcsrc_q;
  reg         irq_q;
  reg  [7:0]  rd_val;
  reg  [7:0]  clr;

  wire        accept;
  wire [7:0]  haddr_idx;
  wire        haddr_ok;
  wire        lcd_en;
  wire        lcd_pm;
  wire        pc_on;
  wire        pu_off;
  wire [7:0]  j_ovr;
  wire [7:0]  die_ovr;
  wire [31:0] pin_in_w;
  wire [31:0] eff_dir_w;
  wire [31:0] pull_w;
  wire [31:0] in_en_w;
  wire [7:0]  j_lvl_new;
  wire [7:0]  pc_event;
  wire [7:0]  wdat;

  assign lcd_en   = lcd_q[`POV_LCD_EN_BIT];
  assign lcd_pm   = lcd_q[`POV_LCD_PM_BIT];
  assign pc_on    = lcd_q[`POV_PC_ON_BIT];
  assign pu_off   = mcu_q[`POV_MCU_NOPU_BIT];
  assign pin_in_w = {PJ_IN, PC_IN, PB_IN, PA_IN};
  assign wdat     = HWDATA[7:0];

  // ==========================================================
  // Port J overrides
  // Bit 7 carries no alternate function, so its overrides stay zero
  assign j_ovr   = {8{lcd_en}} & `POV_J_OVR_MASK; // [R3] [R12]
  // Input buffer is cut only in LCD low-power use of a sensed pin
  assign die_ovr = pcmask_q & {8{pc_on & lcd_en & lcd_pm}}
                   & `POV_J_OVR_MASK; // [R4] [R5]

  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1)
    begin : gen_port
      wire [7:0] ovr_g;
      wire [7:0] die_g;
      assign ovr_g = (g == J_PORT) ? j_ovr : 8'h00;
      assign die_g = (g == J_PORT) ? die_ovr : 8'h00;
      // Direction forced to input, output value never overridden
      assign eff_dir_w[8*g+:8] = dir_q[g] & ~ovr_g; // [R3]
      assign pull_w[8*g+:8]    =
        pov_pullup(dir_q[g], out_q[g], pu_off) & ~ovr_g; // [R3] [R6]
      assign in_en_w[8*g+:8]   = ~die_g; // [R4] [R5]
    end
  endgenerate

  // ==========================================================
  // Pin-change sensing on port J
  // A disabled buffer reads zero, so a pin can not be sensed then
  assign j_lvl_new = pin_in_w[31:24] & in_en_w[31:24];
  // Cutting or restoring a buffer is not a change of the pin itself
  assign pc_event  = (j_lvl_new ^ lvl_q[31:24]) & pcmask_q
                     & in_en_w[31:24] & j_in_en_q & {8{pc_on}}
                     & `POV_J_OVR_MASK; // [R1] [R2]

  // ==========================================================
  // Bus decode
  assign accept    = HSEL & HREADY & HTRANS[1];
  assign haddr_idx = HADDR[9:2];
  assign haddr_ok  = (HADDR[1:0] == 2'b00) &&
                     (HADDR[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});

  always @*
  begin
    rd_val = `POV_RST_BYTE;
    if (map_q)
    begin
      case (addr_q)
        `POV_IDX_A_IN:     rd_val = lvl_q[7:0]; // [R9]
        `POV_IDX_A_DIR:    rd_val = dir_q[0]; // [R8]
        `POV_IDX_A_OUT:    rd_val = out_q[0];
        `POV_IDX_B_IN:     rd_val = lvl_q[15:8]; // [R9]
        `POV_IDX_B_DIR:    rd_val = dir_q[1];
        `POV_IDX_B_OUT:    rd_val = out_q[1]; // [R10]
        `POV_IDX_C_IN:     rd_val = lvl_q[23:16];
        `POV_IDX_C_DIR:    rd_val = dir_q[2];
        `POV_IDX_C_OUT:    rd_val = out_q[2]; // [R10]
        `POV_IDX_MCU:      rd_val = mcu_q & `POV_MCU_RW_MASK; // [R11]
        `POV_IDX_J_IN:     rd_val = lvl_q[31:24];
        `POV_IDX_J_DIR:    rd_val = dir_q[3];
        `POV_IDX_J_OUT:    rd_val = out_q[3];
        `POV_IDX_LCD_CTRL: rd_val = lcd_q;
        `POV_IDX_PC_MASK:  rd_val = pcmask_q;
        `POV_IDX_IRQ_STAT: rd_val = stat_q;
        `POV_IDX_IRQ_MASK: rd_val = imask_q;
        default:           rd_val = `POV_RST_BYTE;
      endcase
    end
  end

  // Read clears only what it returned; a new event still wins
  always @*
  begin
    clr = `POV_RST_BYTE;
    if (rd_pend_q && map_q && addr_q == `POV_IDX_IRQ_STAT)
      clr = stat_q;
    stat_d = (stat_q & ~clr) | pc_event;
  end

  // ==========================================================
  // Bus handshake
  // Reads wait one cycle for the registered read data
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      map_q     <= 1'b0;
      addr_q    <= `POV_RST_BYTE;
      hready_q  <= 1'b1;
      hresp_q   <= 1'b0;
    end
    else
    begin
      rd_pend_q <= accept & ~HWRITE;
      wr_pend_q <= accept & HWRITE;
      hready_q  <= ~(accept & ~HWRITE);
      // Stray accesses read zero, so no error response is needed
      hresp_q   <= 1'b0;
      if (accept)
      begin
        addr_q <= haddr_idx;
        map_q  <= haddr_ok & pov_mapped(haddr_idx);
      end
    end
  end

  // ==========================================================
  // Read data
  // Held until the wait cycle of the next read ends
  always @(posedge CLK)
  begin
    if (SYS_RST)
      hrdata_q <= `POV_RST_WORD;
    else if (rd_pend_q)
      hrdata_q <= {24'h00_0000, rd_val};
  end

  // ==========================================================
  // Software registers
  integer p;
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      for (p = 0; p < NPORT; p = p + 1)
      begin
        out_q[p] <= `POV_RST_BYTE; // [R10]
        dir_q[p] <= `POV_RST_BYTE; // [R8]
      end
      mcu_q    <= `POV_RST_BYTE; // [R11]
      lcd_q    <= `POV_RST_BYTE;
      pcmask_q <= `POV_RST_BYTE;
      imask_q  <= `POV_RST_BYTE;
    end
    else if (wr_pend_q && map_q)
    begin
      // Writes to input level registers are ignored
      case (addr_q)
        `POV_IDX_A_DIR:    dir_q[0] <= wdat; // [R8]
        `POV_IDX_A_OUT:    out_q[0] <= wdat;
        `POV_IDX_B_DIR:    dir_q[1] <= wdat;
        `POV_IDX_B_OUT:    out_q[1] <= wdat; // [R10]
        `POV_IDX_C_DIR:    dir_q[2] <= wdat;
        `POV_IDX_C_OUT:    out_q[2] <= wdat; // [R10]
        `POV_IDX_MCU:      mcu_q <= wdat & `POV_MCU_RW_MASK; // [R11]
        `POV_IDX_J_DIR:    dir_q[3] <= wdat;
        `POV_IDX_J_OUT:    out_q[3] <= wdat;
        `POV_IDX_LCD_CTRL: lcd_q <= wdat;
        `POV_IDX_PC_MASK:  pcmask_q <= wdat;
        `POV_IDX_IRQ_MASK: imask_q <= wdat;
        default:           mcu_q <= mcu_q;
      endcase
    end
  end

  // ==========================================================
  // Input sampling
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      lvl_q   <= `POV_RST_WORD;
      pcsrc_q <= 7'h00;
    end
    else
    begin
      lvl_q   <= pin_in_w & in_en_w; // [R9]
      pcsrc_q <= lvl_q[30:24]; // [R1] [R2]
    end
  end

  // ==========================================================
  // Change status and interrupt
  // Interrupt lags the status by one clock
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      stat_q <= `POV_RST_BYTE;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      irq_q  <= |(stat_q & imask_q);
    end
  end

  // ==========================================================
  // Pin controls
  // Registered so every pin control leaves on a flip-flop
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      pin_out_q <= `POV_RST_WORD;
      oe_n_q    <= 32'hffff_ffff;
      pull_q    <= `POV_RST_WORD;
    end
    else
    begin
      pin_out_q <= {out_q[3], out_q[2], out_q[1], out_q[0]};
      oe_n_q    <= ~eff_dir_w; // [R3] [R12]
      pull_q    <= pull_w; // [R6] [R7]
    end
  end

  // ==========================================================
  // Port J alternate functions
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      j_in_en_q <= 8'hff;
      lcd_pin_q <= 7'h00;
    end
    else
    begin
      j_in_en_q <= in_en_w[31:24]; // [R4] [R5]
      lcd_pin_q <= j_ovr[6:0]; // [R1] [R2]
    end
  end

  // ==========================================================
  // Outputs
  assign HRDATA          = hrdata_q;
  assign HREADYOUT       = hready_q;
  assign HRESP           = hresp_q;
  assign PA_OUT          = pin_out_q[7:0];
  assign PB_OUT          = pin_out_q[15:8];
  assign PC_OUT          = pin_out_q[23:16];
  assign PJ_OUT          = pin_out_q[31:24];
  assign PA_OE_N         = oe_n_q[7:0];
  assign PB_OE_N         = oe_n_q[15:8];
  assign PC_OE_N         = oe_n_q[23:16];
  assign PJ_OE_N         = oe_n_q[31:24];
  assign PA_PULLUP       = pull_q[7:0];
  assign PB_PULLUP       = pull_q[15:8];
  assign PC_PULLUP       = pull_q[23:16];
  assign PJ_PULLUP       = pull_q[31:24];
  assign PJ_INPUT_EN     = j_in_en_q;
  assign LCD_SEG_CONNECT = lcd_pin_q;
  assign PIN_CHANGE_SRC  = pcsrc_q;
  assign IRQ             = irq_q;

endmodule // pov_port_regs

// [pov_defines.vh]
/*
  Register indices, field positions, reset values and masks for the
  port override block. Assumes the includer maps index n to byte
  address 4*n on a 32-bit register bus.
*/
`ifndef POV_DEFINES_VH
`define POV_DEFINES_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define POV_IDX_A_IN     8'h00
`define POV_IDX_A_DIR    8'h01
`define POV_IDX_A_OUT    8'h02
`define POV_IDX_B_IN     8'h03
`define POV_IDX_B_DIR    8'h04
`define POV_IDX_B_OUT    8'h05
`define POV_IDX_C_IN     8'h06
`define POV_IDX_C_DIR    8'h07
`define POV_IDX_C_OUT    8'h08
`define POV_IDX_MCU      8'h35
`define POV_IDX_J_IN     8'h40
`define POV_IDX_J_DIR    8'h41
`define POV_IDX_J_OUT    8'h42
`define POV_IDX_LCD_CTRL 8'h43
`define POV_IDX_PC_MASK  8'h44
`define POV_IDX_IRQ_STAT 8'h45
`define POV_IDX_IRQ_MASK 8'h46

// ==========================================================
// Fields
`define POV_MCU_NOPU_BIT 4
`define POV_MCU_RW_MASK  8'hf3
`define POV_LCD_EN_BIT   0
`define POV_LCD_PM_BIT   1
`define POV_PC_ON_BIT    2
`define POV_J_OVR_MASK   8'h7f

// ==========================================================
// Reset values
`define POV_RST_BYTE     8'h00
`define POV_RST_WORD     32'h0000_0000

`endif

// [pov_port_regs_sva.sv]
/* Port-level checker for pov_port_regs.
   Assumes one clock domain and HREADY tied to HREADYOUT. */
`timescale 1ns/100ps
module pov_port_regs_sva (
  input wire       CLK,
  input wire       SYS_RST,
  input wire       HSEL,
  input wire [1:0] HTRANS,
  input wire       HWRITE,
  input wire       HREADY,
  input wire       HREADYOUT,
  input wire       HRESP,
  input wire [7:0] PA_OUT,
  input wire [7:0] PA_OE_N,
  input wire [7:0] PA_PULLUP,
  input wire [7:0] PJ_IN,
  input wire [7:0] PJ_OE_N,
  input wire [7:0] PJ_PULLUP,
  input wire [7:0] PJ_INPUT_EN,
  input wire [6:0] LCD_SEG_CONNECT,
  input wire [6:0] PIN_CHANGE_SRC
);
  // ====================================
  // Bus handshake steps
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_take(w);
    HSEL && HREADY && HTRANS[1] && (HWRITE == w);
  endsequence
  sequence s_one_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  // ====================================
  // Assertions
  a_read_wait: assert property (s_take(1'b0) |=> s_one_wait)
    else $error("read data phase not one wait state");
  a_write_nowait: assert property (s_take(1'b1) |=> HREADYOUT)
    else $error("write data phase stalled");
  a_resp_okay: assert property (HRESP == 1'b0)
    else $error("error response seen");
  a_reset_vals: assert property ($fell(SYS_RST) |->
    PA_OUT == 8'h00 && PA_OE_N == 8'hff && PA_PULLUP == 8'h00)
    else $error("port A outputs not at reset values");
  a_lcd_pull_off: assert property
    ((PJ_PULLUP[6:0] & LCD_SEG_CONNECT) == 7'h00)
    else $error("pull-up on an LCD pin");
  a_lcd_dir_in: assert property
    ((PJ_OE_N[6:0] | ~LCD_SEG_CONNECT) == 7'h7f)
    else $error("LCD pin still driven");
  a_pull_input: assert property
    ((PA_PULLUP & ~(PA_OE_N & PA_OUT)) == 8'h00)
    else $error("pull-up on driven or low pin");
  a_bit7_free: assert property (PJ_INPUT_EN[7])
    else $error("bit 7 input buffer overridden");
  // Enable held three cycles so the buffer state is settled
  a_src_follow: assert property
    ((&PJ_INPUT_EN[1:0]) && $past(&PJ_INPUT_EN[1:0]) &&
     $past(&PJ_INPUT_EN[1:0], 2) && !$past(SYS_RST) &&
     !$past(SYS_RST, 2) |-> PIN_CHANGE_SRC[1:0] == $past(PJ_IN[1:0], 2))
    else $error("change source not following pin");
endmodule // pov_port_regs_sva

// [pov_pin_model.sv]
/* Pin level model for one 8-bit port.
   Assumes the outside level is given by the bench, no bus keeper. */
`timescale 1ns/100ps
module pov_pin_model (
  input  wire [7:0] out_v,
  input  wire [7:0] oe_n,
  input  wire [7:0] pull_on,
  input  wire [7:0] ext,
  output wire [7:0] level
);
  // Driven pin wins, then pull-up, then the outside level
  assign level = (~oe_n & out_v) | (oe_n & (pull_on | ext));
endmodule // pov_pin_model

// [tb_pov_port_regs.sv]
/* Self-checking bench for pov_port_regs over AHB-Lite.
   Assumes pov_defines.vh on the include path. */
`timescale 1ns/100ps
`include "pov_defines.vh"
module tb_pov_port_regs;
  logic        clk = 0;
  logic        rst = 1;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] hwdata = 0;
  logic [7:0]  ext [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  wire  [31:0] hrdata;
  wire         hready, hresp, irq;
  wire  [7:0]  o [4], oe [4], pu [4], lv [4];
  wire  [7:0]  ie;
  wire  [6:0]  lcd_pin, src;
  int          failures = 0;
  int          checks_done = 0;
  logic [31:0] v;
  logic [7:0]  tbl [6] = '{`POV_IDX_A_DIR, `POV_IDX_A_OUT, `POV_IDX_B_DIR,
    `POV_IDX_B_OUT, `POV_IDX_C_OUT, `POV_IDX_MCU};
  always #2.5 clk = ~clk;
  pov_port_regs pov_port_regs_inst (.CLK(clk), .SYS_RST(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .PA_IN(lv[0]), .PA_OUT(o[0]), .PA_OE_N(oe[0]),
    .PA_PULLUP(pu[0]), .PB_IN(lv[1]), .PB_OUT(o[1]), .PB_OE_N(oe[1]),
    .PB_PULLUP(pu[1]), .PC_IN(lv[2]), .PC_OUT(o[2]), .PC_OE_N(oe[2]),
    .PC_PULLUP(pu[2]), .PJ_IN(lv[3]), .PJ_OUT(o[3]), .PJ_OE_N(oe[3]),
    .PJ_PULLUP(pu[3]), .PJ_INPUT_EN(ie), .LCD_SEG_CONNECT(lcd_pin),
    .PIN_CHANGE_SRC(src), .IRQ(irq));
  for (genvar g = 0; g < 4; g++)
  begin : pm
    pov_pin_model pov_pin_model_inst (.out_v(o[g]), .oe_n(oe[g]),
      .pull_on(pu[g]), .ext(ext[g]), .level(lv[g]));
  end
  // ====================================
  // Bus and compare tasks
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {2'b00, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, idx, d, x);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] e);
    xfer(1'b0, idx, 32'h0, v);
    chk(v, e);
  endtask
  // Outputs land one edge after the write; four is a safe margin
  task automatic st;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ====================================
  // Tests
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rc(tbl[i], 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wr(tbl[i], 32'hff);
      rc(tbl[i], (i == 5) ? 32'hf3 : 32'hff);
    end
    rc(8'h20, 32'h0);
    wr(`POV_IDX_MCU, 32'h0);
    wr(`POV_IDX_A_DIR, 32'h0f);
    wr(`POV_IDX_A_OUT, 32'h3c);
    st;
    chk({24'h0, o[1]}, 32'hff);
    chk({24'h0, oe[1]}, 32'h0);
    chk({24'h0, pu[2]}, 32'hff);
    chk({24'h0, pu[0]}, 32'h30);
    rc(`POV_IDX_A_IN, 32'h3c);
    @(posedge clk) ext[0] <= 8'hc0;
    rc(`POV_IDX_A_IN, 32'hfc);
    wr(`POV_IDX_MCU, 32'h10);
    st;
    chk({24'h0, pu[0]}, 32'h0);
    chk({24'h0, pu[2]}, 32'h0);
    rc(`POV_IDX_A_IN, 32'hcc);
    wr(`POV_IDX_MCU, 32'h0);
    // LCD takes port J; output value must stay untouched
    wr(`POV_IDX_J_DIR, 32'hff);
    wr(`POV_IDX_J_OUT, 32'h55);
    wr(`POV_IDX_LCD_CTRL, 32'h1);
    st;
    chk({24'h0, oe[3]}, 32'h7f);
    chk({24'h0, o[3]}, 32'h55);
    chk({24'h0, pu[3]}, 32'h0);
    chk({25'h0, lcd_pin}, 32'h7f);
    wr(`POV_IDX_LCD_CTRL, 32'h0);
    st;
    chk({24'h0, oe[3]}, 32'h0);
    rc(`POV_IDX_J_IN, 32'h55);
    wr(`POV_IDX_PC_MASK, 32'h11);
    wr(`POV_IDX_LCD_CTRL, 32'h7);
    st;
    chk({24'h0, ie}, 32'hee);
    wr(`POV_IDX_LCD_CTRL, 32'h3);
    st;
    chk({24'h0, ie}, 32'hff);
    // Pin-change event on J bit 1: raise, read-clear, then masked
    wr(`POV_IDX_J_DIR, 32'h0);
    wr(`POV_IDX_PC_MASK, 32'h02);
    wr(`POV_IDX_IRQ_MASK, 32'h02);
    wr(`POV_IDX_LCD_CTRL, 32'h4);
    st;
    @(posedge clk) ext[3] <= 8'h02;
    st;
    chk({25'h0, src}, 32'h57);
    chk({31'h0, irq}, 32'h1);
    rc(`POV_IDX_IRQ_STAT, 32'h02);
    st;
    chk({31'h0, irq}, 32'h0);
    wr(`POV_IDX_IRQ_MASK, 32'h0);
    @(posedge clk) ext[3] <= 8'h00;
    st;
    chk({31'h0, irq}, 32'h0);
    rc(`POV_IDX_IRQ_STAT, 32'h02);
    wrap_up;
  end
  initial
  begin
    #20000;
    failures++;
    wrap_up;
  end
endmodule // tb_pov_port_regs
bind pov_port_regs pov_port_regs_sva chk_inst (.CLK, .SYS_RST, .HSEL,
  .HTRANS, .HWRITE, .HREADY, .HREADYOUT, .HRESP, .PA_OUT, .PA_OE_N,
  .PA_PULLUP, .PJ_IN, .PJ_OE_N, .PJ_PULLUP, .PJ_INPUT_EN,
  .LCD_SEG_CONNECT, .PIN_CHANGE_SRC);
